// >>> core/dwd_decoder.sv
// Purpose: Split a received command word into one-cycle register strobes
// Assumes: Word and its strobe come from logic on mclk
// Notes: All outputs are registered; strobes last one cycle
`timescale 1ns/10ps
module dwd_decoder (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Received word
	input wire logic word_valid,
	input wire logic [dwd_pkg::WORD_W-1:0] word_in,
	// Decoded access
	output dwd_pkg::dwd_target_t target,
	output logic gain_wr,
	output logic offs_wr,
	output logic input_wr,
	output logic ctrl_wr,
	output logic rdback_start,
	output logic recalc_start,
	output logic [dwd_pkg::GAIN_W-1:0] gain_data
);
	import dwd_pkg::*;

	// ************
	// Field helpers
	// ************
	// Write and kind helpers are shared by the next-state logic and the checks, so both read the word alike
	function automatic logic word_is_write(input logic [WORD_W-1:0] w);
		return ~w[RW_BIT];
	endfunction : word_is_write

	function automatic logic [1:0] word_kind(input logic [WORD_W-1:0] w);
		return w[KIND_HI:KIND_LO];
	endfunction : word_kind

	function automatic dwd_target_t word_fields(input logic [WORD_W-1:0] w);
		dwd_target_t t;
		t.ch_mask = w[CH_HI:CH_LO];
		t.reg_set = w[SET_HI:SET_LO];
		t.dac_sel = w[DAC_HI:DAC_LO];
		t.data = w[DATA_W-1:0];
		return t;
	endfunction : word_fields

	function automatic logic [GAIN_W-1:0] word_gain(input logic [WORD_W-1:0] w);
		// Lowest data bit has no home in the gain register
		return w[DATA_W-1:DATA_W-GAIN_W];
	endfunction : word_gain

	// ************
	// Decode
	// ************
	dwd_target_t tgt_r, tgt_nxt;
	logic gain_r, gain_nxt, offs_r, offs_nxt, inp_r, inp_nxt;
	logic ctrl_r, ctrl_nxt, rd_r, rd_nxt;
	logic [GAIN_W-1:0] gd_r, gd_nxt;
	logic is_wr;
	logic [1:0] kind;

	always_comb begin
		tgt_nxt = tgt_r;
		gd_nxt = gd_r;
		gain_nxt = 1'b0;
		offs_nxt = 1'b0;
		inp_nxt = 1'b0;
		ctrl_nxt = 1'b0;
		rd_nxt = 1'b0;
		is_wr = word_is_write(word_in);
		kind = word_kind(word_in);
		// Only a complete word is decoded
		if (word_valid) begin
			tgt_nxt = word_fields(word_in);
			gd_nxt = word_gain(word_in);
			rd_nxt = ~is_wr;
			if (is_wr) begin
				unique case (kind)
					KIND_CTRL: ctrl_nxt = 1'b1;
					KIND_GAIN: gain_nxt = 1'b1;
					KIND_OFFS: offs_nxt = 1'b1;
					// The shared offset DAC arrives here too, as a plain input write
					KIND_INPUT: inp_nxt = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_r <= '0;
			gd_r <= '0;
			gain_r <= 1'b0;
			offs_r <= 1'b0;
			inp_r <= 1'b0;
			ctrl_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			tgt_r <= tgt_nxt;
			gd_r <= gd_nxt;
			gain_r <= gain_nxt;
			offs_r <= offs_nxt;
			inp_r <= inp_nxt;
			ctrl_r <= ctrl_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign target = tgt_r;
	assign gain_data = gd_r;
	assign gain_wr = gain_r;
	assign offs_wr = offs_r;
	assign input_wr = inp_r;
	assign ctrl_wr = ctrl_r;
	assign rdback_start = rd_r;
	// Recompute follows input loads only; gain or offset updates leave it idle
	assign recalc_start = inp_r;

	// ************
	// Checks
	// ************
	// Helper: remembers that a word was taken at the previous edge
	logic word_d_r, word_d_nxt;

	always_comb begin
		word_d_nxt = word_valid;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			word_d_r <= 1'b0;
		end else begin
			word_d_r <= word_d_nxt;
		end
	end

	sequence s_write_word(logic [1:0] k);
		word_valid && word_is_write(word_in) && word_kind(word_in) == k;
	endsequence

	sequence s_read_word;
		word_valid && !word_is_write(word_in);
	endsequence

	sequence s_no_word;
		!word_valid;
	endsequence

	// ************
	// Strobe checks
	// ************
	a_gain_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
		s_write_word(KIND_GAIN) |=>
		gain_wr && !offs_wr && !input_wr && !ctrl_wr)
		else $error("gain strobe missing");

	a_offs_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
		s_write_word(KIND_OFFS) |=>
		offs_wr && !gain_wr && !input_wr && !ctrl_wr)
		else $error("offset strobe missing");

	a_ctrl_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
		s_write_word(KIND_CTRL) |=>
		ctrl_wr && !gain_wr && !offs_wr && !input_wr)
		else $error("control write missing");

	a_input_recalc: assert property (@(posedge mclk) disable iff (!rst_n)
		s_write_word(KIND_INPUT) |=>
		input_wr && recalc_start && !gain_wr && !offs_wr)
		else $error("input load without recalc");

	// A recompute on a coefficient update would corrupt a calibrated output
	a_no_recalc: assert property (@(posedge mclk) disable iff (!rst_n)
		(gain_wr || offs_wr || ctrl_wr || rdback_start) |->
		!recalc_start)
		else $error("recalc on non input write");

	a_read_start: assert property (@(posedge mclk) disable iff (!rst_n)
		s_read_word |=>
		rdback_start && !gain_wr && !offs_wr && !input_wr && !ctrl_wr)
		else $error("readback not started");

	a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
		word_valid && word_is_write(word_in) |=>
		(gain_wr || offs_wr || input_wr || ctrl_wr) && !rdback_start)
		else $error("write word left no strobe");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
		s_no_word |=>
		!rdback_start && !gain_wr && !offs_wr && !input_wr && !ctrl_wr && !recalc_start)
		else $error("strobe without word");

	// Two strobes at once would load two registers from one word
	a_one_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
		$onehot0({gain_wr, offs_wr, input_wr, ctrl_wr, rdback_start}))
		else $error("more than one strobe");

	a_one_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		(gain_wr || offs_wr || input_wr || ctrl_wr || rdback_start) ==
		word_d_r)
		else $error("answer count differs from words");

	// ************
	// Field checks
	// ************
	a_gain_bits: assert property (@(posedge mclk) disable iff (!rst_n)
		word_valid |=>
		gain_data == $past(word_in[DATA_W-1:DATA_W-GAIN_W]))
		else $error("gain data wrong");

	a_mask_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		word_valid |=> target.ch_mask == $past(word_in[CH_HI:CH_LO])
		&& target.dac_sel == $past(word_in[DAC_HI:DAC_LO]))
		else $error("mask or address wrong");

	a_set_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		word_valid |=>
		target.reg_set == $past(word_in[SET_HI:SET_LO]))
		else $error("register set wrong");

	a_data_whole: assert property (@(posedge mclk) disable iff (!rst_n)
		word_valid |=>
		target.data == $past(word_in[DATA_W-1:0]))
		else $error("data field wrong");

	// Stale lines between words must never leak into the held fields
	a_target_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		s_no_word |=>
		$stable(target) && $stable(gain_data))
		else $error("fields changed without word");
endmodule : dwd_decoder

// >>> core/dwd_pkg.sv
// Purpose: Constants and types for the DAC register word decoder
// Assumes: Command word arrives whole as a 29-bit parallel word with a strobe
// Notes: Field positions, kinds and widths live here only
// Functional notes
// - Bit 28 low writes the data into the addressed register.
// - Bit 28 high starts a readback of the addressed register.
// - Bits 27..24 select channels; any combination programs several at once.
// - Bits 23..22: 01 gain, 10 offset, 11 input data register.
// - Kind 00 targets system control or channel control register instead.
// - Address bits 21..19 choose the register set of the DAC.
// - Address bits 18..16 choose the DAC within the channel.
// - Bits 15..0 carry data, stored whole for input and offset registers.
// - Gain register keeps only data bits 15..1.
// - Corrected code recomputed only on input data load.
package dwd_pkg;
	localparam int WORD_W = 29;
	localparam int RW_BIT = 28;
	localparam int CH_HI = 27;
	localparam int CH_LO = 24;
	localparam int KIND_HI = 23;
	localparam int KIND_LO = 22;
	localparam int SET_HI = 21;
	localparam int SET_LO = 19;
	localparam int DAC_HI = 18;
	localparam int DAC_LO = 16;
	localparam int DATA_W = 16;
	localparam int GAIN_W = 15;
	localparam int NUM_CH = 4;
	localparam logic [1:0] KIND_CTRL = 2'h0;
	localparam logic [1:0] KIND_GAIN = 2'h1;
	localparam logic [1:0] KIND_OFFS = 2'h2;
	localparam logic [1:0] KIND_INPUT = 2'h3;

	typedef struct packed {
		logic [NUM_CH-1:0] ch_mask;
		logic [2:0] reg_set;
		logic [2:0] dac_sel;
		logic [DATA_W-1:0] data;
	} dwd_target_t;
endpackage : dwd_pkg

// >>> verification/dwd_decoder_tb.sv
// Purpose: Self-checking bench for the command word decoder
// Assumes: One word per strobe, answer one cycle later
// Notes: Random words plus every kind in both directions
`timescale 1ns/10ps
module dwd_decoder_tb;
	import dwd_pkg::*;
	logic mclk, rst_n, word_valid;
	logic [WORD_W-1:0] word_in;
	dwd_target_t target;
	logic gain_wr, offs_wr, input_wr, ctrl_wr, rdback_start, recalc_start;
	logic [GAIN_W-1:0] gain_data;
	int mismatches, num_checks;
	dwd_host_model host_u (.mclk(mclk), .word_valid(word_valid), .word_in(word_in));
	dwd_decoder dut_u (.mclk(mclk), .rst_n(rst_n), .word_valid(word_valid),
		.word_in(word_in), .target(target), .gain_wr(gain_wr), .offs_wr(offs_wr),
		.input_wr(input_wr), .ctrl_wr(ctrl_wr), .rdback_start(rdback_start),
		.recalc_start(recalc_start), .gain_data(gain_data));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [5:0] exp_st(input logic [WORD_W-1:0] w);
		logic wr;
		logic [1:0] k;
		wr = !w[RW_BIT];
		k = w[KIND_HI:KIND_LO];
		return {wr && k == KIND_GAIN, wr && k == KIND_OFFS, wr && k == KIND_INPUT,
			wr && k == KIND_CTRL, !wr, wr && k == KIND_INPUT};
	endfunction : exp_st
	function automatic dwd_target_t exp_tg(input logic [WORD_W-1:0] w);
		return {w[CH_HI:CH_LO], w[SET_HI:SET_LO], w[DAC_HI:DAC_LO], w[DATA_W-1:0]};
	endfunction : exp_tg
	function automatic logic [5:0] strobes_now();
		return {gain_wr, offs_wr, input_wr, ctrl_wr, rdback_start, recalc_start};
	endfunction : strobes_now
	task automatic run(input logic [WORD_W-1:0] w);
		host_u.send(w);
		#1;
		check(32'(strobes_now()), 32'(exp_st(w)));
		check(32'(target), 32'(exp_tg(w)));
		check(32'(gain_data), 32'(w[DATA_W-1:1]));
		// Strobes stand one cycle; fields stay until the next word
		@(posedge mclk);
		#1;
		check(32'(strobes_now()), 32'h0);
		check(32'(target), 32'(exp_tg(w)));
	endtask : run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		mismatches++;
		$display("Error at %0t: run hung", $time);
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		void'($urandom(32'h81e5));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		check(32'(strobes_now()), 32'h0);
		check(32'(target), 32'h0);
		check(32'(gain_data), 32'h0);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			run({k[2], 4'h5, k[1:0], 22'h2a5a5b});
		end
		run({1'b0, 4'hf, KIND_INPUT, 6'h0, 16'hffff});
		// Lowest data bit must vanish on a gain write
		run({1'b0, 4'h1, KIND_GAIN, 6'h3f, 16'h0001});
		$display("directed test done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		check(32'(strobes_now()), 32'h0);
		check(32'(target), 32'h0);
		@(posedge mclk);
		rst_n <= 1'b1;
		run({1'b0, 4'ha, KIND_OFFS, 6'h09, 16'h8001});
		$display("mid reset test done");
		repeat (100) run(29'($urandom()));
		$display("random test done");
		wrap_up();
	end
endmodule : dwd_decoder_tb

// >>> verification/dwd_host_model.sv
// Purpose: Host side that hands whole command words to the decoder
// Assumes: Serial shifting is done before this point
// Notes: Released word lines show the inverse of the last word
`timescale 1ns/10ps
module dwd_host_model (
	// Clock
	input wire logic mclk,
	// Word handoff
	output logic word_valid,
	output logic [dwd_pkg::WORD_W-1:0] word_in
);
	import dwd_pkg::*;
	initial begin
		word_valid = 1'b0;
		word_in = '0;
	end
	task automatic send(input logic [WORD_W-1:0] w);
		@(posedge mclk);
		word_valid <= 1'b1;
		word_in <= w;
		@(posedge mclk);
		word_valid <= 1'b0;
		// Stale data must not look like a fresh word
		word_in <= ~w;
	endtask : send
endmodule : dwd_host_model
